// ==== verilog/fic_pkg.sv ====
// Constants and types shared by the interface configuration register block
package fic_pkg;

	// ==========================================================
	// Register layout
	localparam int CFG_W = 8;
	localparam int BIT_ADDR_LEN = 7;
	localparam int BIT_QUAD_INSTR = 6;
	localparam int BIT_PIN_RESET = 5;
	localparam int BIT_RESERVED = 4;
	localparam int DUMMY_MSB = 3;
	localparam int DUMMY_LSB = 0;
	localparam logic [7:0] WRITE_MASK = 8'hEF;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// ==========================================================
	// Command codes
	localparam logic [7:0] OP_READ_ANY = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY = 8'h71;
	// Default for the wide address command code, value is arbitrary
	localparam logic [7:0] OP_WIDE_ADDR_DEFAULT = 8'hE0;

	// ==========================================================
	// Read latency figures
	localparam logic [2:0] MODE_CYC_NONE = 3'h0;
	localparam logic [2:0] MODE_CYC_DUAL = 3'h4;
	localparam logic [2:0] MODE_CYC_QUAD = 3'h2;
	localparam logic [2:0] MODE_CYC_DDR = 3'h1;
	localparam logic [3:0] DUMMY_PLAIN = 4'h0;
	localparam logic [3:0] DUMMY_PARAM_TABLE = 4'h8;

	typedef enum logic [2:0] {
		FIC_RD_PLAIN,
		FIC_RD_FAST,
		FIC_RD_DUAL,
		FIC_RD_QUAD,
		FIC_RD_DDR_QUAD,
		FIC_RD_OTP,
		FIC_RD_ANY_REG,
		FIC_RD_PARAM_TABLE
	} fic_read_t;

endpackage

// ==== verilog/fic_lat_if.sv ====
// Interface between the register core and the read latency calculator
`timescale 1ns/1ps
interface fic_lat_if;
	fic_pkg::fic_read_t read_kind;
	logic [3:0] dummy_count;
	logic [2:0] mode_cycles;
	logic [3:0] dummy_cycles;

	modport core
	(
		output read_kind,
		output dummy_count,
		input mode_cycles,
		input dummy_cycles
	);

	modport calc
	(
		input read_kind,
		input dummy_count,
		output mode_cycles,
		output dummy_cycles
	);
endinterface

// ==== verilog/fic_latency.sv ====
// Read latency calculator: mode cycles and dummy cycles per read kind
`timescale 1ns/1ps
module fic_latency
(
	fic_lat_if.calc lat
);

	// ==========================================================
	// Decoding
	function automatic logic [2:0] fic_mode_of(input fic_pkg::fic_read_t kind);
		case (kind)
			fic_pkg::FIC_RD_DUAL: fic_mode_of = fic_pkg::MODE_CYC_DUAL;
			fic_pkg::FIC_RD_QUAD: fic_mode_of = fic_pkg::MODE_CYC_QUAD;
			fic_pkg::FIC_RD_DDR_QUAD: fic_mode_of = fic_pkg::MODE_CYC_DDR;
			default: fic_mode_of = fic_pkg::MODE_CYC_NONE;
		endcase
	endfunction

	function automatic logic [3:0] fic_dummy_of(input fic_pkg::fic_read_t kind, input logic [3:0] code);
		case (kind)
			fic_pkg::FIC_RD_PLAIN: fic_dummy_of = fic_pkg::DUMMY_PLAIN;
			fic_pkg::FIC_RD_PARAM_TABLE: fic_dummy_of = fic_pkg::DUMMY_PARAM_TABLE;
			default: fic_dummy_of = code;
		endcase
	endfunction

	// Mode cycles come first and are not part of the dummy count
	assign lat.mode_cycles = fic_mode_of(lat.read_kind);
	assign lat.dummy_cycles = fic_dummy_of(lat.read_kind, lat.dummy_count);

endmodule

// ==== verilog/flash_interface_config.sv ====
// Volatile interface configuration register with link command port
`timescale 1ns/1ps
module flash_interface_config
#(
	parameter logic [7:0] WIDE_ADDR_OPCODE = fic_pkg::OP_WIDE_ADDR_DEFAULT
)
(
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic DATA_LINE_THREE,
	input wire logic SOFT_RESET,
	input wire logic QUAD_IO_ENABLE,
	input wire logic [7:0] NV_CONFIG,
	input wire fic_pkg::fic_read_t READ_KIND,
	input wire logic CMD_STROBE,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_WDATA,
	output logic [7:0] CONFIG,
	output logic ADDR_FOUR_BYTES,
	output logic QUAD_INSTR,
	output logic PIN_RESET_REQ,
	output logic SET_QUAD_IO,
	output logic [2:0] MODE_CYCLES,
	output logic [3:0] DUMMY_CYCLES,
	output logic [7:0] LINK_RDATA,
	output logic LINK_RDATA_VALID,
	output logic LINK_BUSY
);

	// ==========================================================
	// Link domain: state
	logic wr_req;
	logic wr_is_wide;
	logic [7:0] wr_data;
	logic wr_ack_s1;
	logic wr_ack_s2;
	logic snap_req_s1;
	logic snap_req_s2;
	logic snap_seen;
	logic [7:0] link_copy;

	// ==========================================================
	// Core domain: state, of which the link side reads wr_ack, snap_req and snap_hold
	logic wr_req_s1;
	logic wr_req_s2;
	logic wr_ack;
	logic snap_ack_s1;
	logic snap_ack_s2;
	logic snap_req;
	logic [7:0] snap_hold;
	logic cs_s1;
	logic cs_s2;
	logic io3_s1;
	logic io3_s2;
	logic loaded;

	// ==========================================================
	// Shared decoding
	// Matches a strobed command against one opcode
	function automatic logic fic_is_op(input logic strobe, input logic [7:0] code, input logic [7:0] want);
		fic_is_op = strobe && (code == want);
	endfunction

	// Clears the reserved bit of any value headed for the register
	function automatic logic [7:0] fic_masked(input logic [7:0] value);
		fic_masked = value & fic_pkg::WRITE_MASK;
	endfunction

	// ==========================================================
	// Link domain: command wires
	wire cmd_write = fic_is_op(CMD_STROBE, CMD_OPCODE, fic_pkg::OP_WRITE_ANY);
	wire cmd_read = fic_is_op(CMD_STROBE, CMD_OPCODE, fic_pkg::OP_READ_ANY);
	wire cmd_wide = fic_is_op(CMD_STROBE, CMD_OPCODE, WIDE_ADDR_OPCODE);
	wire link_idle = (wr_req == wr_ack_s2);
	wire link_take = (cmd_write || cmd_wide) && link_idle;
	wire next_wr_req = link_take ? ~wr_req : wr_req;
	wire snap_new = (snap_req_s2 != snap_seen);

	// ==========================================================
	// Link domain: write request handshake
	always_ff @(posedge SCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wr_req <= 1'b0;
			wr_ack_s1 <= 1'b0;
			wr_ack_s2 <= 1'b0;
			LINK_BUSY <= 1'b0;
		end
		else
		begin
			wr_req <= next_wr_req;
			wr_ack_s1 <= wr_ack;
			wr_ack_s2 <= wr_ack_s1;
			LINK_BUSY <= (next_wr_req != wr_ack_s2);
		end
	end

	// ==========================================================
	// Link domain: write data, held steady until the core acknowledges
	always_ff @(posedge SCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wr_is_wide <= 1'b0;
			wr_data <= 8'h00;
		end
		else if (link_take)
		begin
			wr_is_wide <= cmd_wide;
			wr_data <= CMD_WDATA;
		end
	end

	// ==========================================================
	// Link domain: register copy
	always_ff @(posedge SCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			snap_req_s1 <= 1'b0;
			snap_req_s2 <= 1'b0;
			snap_seen <= 1'b0;
			link_copy <= fic_pkg::CFG_RESET;
		end
		else
		begin
			snap_req_s1 <= snap_req;
			snap_req_s2 <= snap_req_s1;
			snap_seen <= snap_req_s2;
			if (snap_new)
			begin
				link_copy <= snap_hold;
			end
		end
	end

	// ==========================================================
	// Link domain: read answer, valid for one link cycle
	always_ff @(posedge SCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			LINK_RDATA <= 8'h00;
			LINK_RDATA_VALID <= 1'b0;
		end
		else
		begin
			LINK_RDATA_VALID <= cmd_read;
			if (cmd_read)
			begin
				LINK_RDATA <= link_copy;
			end
		end
	end

	// ==========================================================
	// Core domain: handshake synchronisers
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wr_req_s1 <= 1'b0;
			wr_req_s2 <= 1'b0;
			snap_ack_s1 <= 1'b0;
			snap_ack_s2 <= 1'b0;
		end
		else if (CLK_EN)
		begin
			wr_req_s1 <= wr_req;
			wr_req_s2 <= wr_req_s1;
			snap_ack_s1 <= snap_seen;
			snap_ack_s2 <= snap_ack_s1;
		end
	end

	// ==========================================================
	// Core domain: pin synchronisers, idle high so reset gives no false pin reset
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			io3_s1 <= 1'b1;
			io3_s2 <= 1'b1;
		end
		else if (CLK_EN)
		begin
			cs_s1 <= CS_N;
			cs_s2 <= cs_s1;
			io3_s1 <= DATA_LINE_THREE;
			io3_s2 <= io3_s1;
		end
	end

	// ==========================================================
	// Core domain: register update decode
	wire apply_event = (wr_req_s2 != wr_ack);
	wire line_free = cs_s2 || !QUAD_IO_ENABLE;
	wire pin_reset = CONFIG[fic_pkg::BIT_PIN_RESET] && line_free && !io3_s2;
	wire reload = !loaded || SOFT_RESET || pin_reset;
	wire [7:0] nv_value = fic_masked(NV_CONFIG);
	wire [7:0] write_value = fic_masked(wr_data);
	wire [7:0] wide_value = CONFIG | (8'h01 << fic_pkg::BIT_ADDR_LEN);
	wire [7:0] event_value = wr_is_wide ? wide_value : write_value;
	wire [7:0] next_config = reload ? nv_value : (apply_event ? event_value : CONFIG);
	wire next_set_quad = !reload && apply_event && !wr_is_wide && write_value[fic_pkg::BIT_QUAD_INSTR];
	wire snap_idle = (snap_req == snap_ack_s2);
	wire snap_send = snap_idle && (snap_hold != CONFIG);

	// ==========================================================
	// Core domain: configuration register
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			loaded <= 1'b0;
			wr_ack <= 1'b0;
			CONFIG <= fic_pkg::CFG_RESET;
		end
		else if (CLK_EN)
		begin
			loaded <= 1'b1;
			wr_ack <= wr_req_s2;
			CONFIG <= next_config;
		end
	end

	// ==========================================================
	// Core domain: field outputs, updated in step with the register
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ADDR_FOUR_BYTES <= 1'b0;
			QUAD_INSTR <= 1'b0;
			SET_QUAD_IO <= 1'b0;
			PIN_RESET_REQ <= 1'b0;
		end
		else if (CLK_EN)
		begin
			ADDR_FOUR_BYTES <= next_config[fic_pkg::BIT_ADDR_LEN];
			QUAD_INSTR <= next_config[fic_pkg::BIT_QUAD_INSTR];
			SET_QUAD_IO <= next_set_quad;
			PIN_RESET_REQ <= pin_reset;
		end
	end

	// ==========================================================
	// Core domain: snapshot towards the link
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			snap_req <= 1'b0;
			snap_hold <= fic_pkg::CFG_RESET;
		end
		else if (CLK_EN)
		begin
			if (snap_send)
			begin
				snap_req <= ~snap_req;
				snap_hold <= CONFIG;
			end
		end
	end

	// ==========================================================
	// Read latency for the selected read kind
	fic_lat_if lat ();

	assign lat.read_kind = READ_KIND;
	assign lat.dummy_count = CONFIG[fic_pkg::DUMMY_MSB:fic_pkg::DUMMY_LSB];

	fic_latency u_latency
	(
		.lat(lat)
	);

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			MODE_CYCLES <= fic_pkg::MODE_CYC_NONE;
			DUMMY_CYCLES <= fic_pkg::DUMMY_PLAIN;
		end
		else if (CLK_EN)
		begin
			MODE_CYCLES <= lat.mode_cycles;
			DUMMY_CYCLES <= lat.dummy_cycles;
		end
	end

endmodule

// ==== sim/fic_sva.sv ====
// Checker for the interface configuration register
`timescale 1ns/1ps
module fic_sva
(
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic SCK,
	input wire logic [7:0] NV_CONFIG,
	input wire fic_pkg::fic_read_t READ_KIND,
	input wire logic CMD_STROBE,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CONFIG,
	input wire logic ADDR_FOUR_BYTES,
	input wire logic PIN_RESET_REQ,
	input wire logic SET_QUAD_IO,
	input wire logic [2:0] MODE_CYCLES,
	input wire logic [3:0] DUMMY_CYCLES,
	input wire logic LINK_RDATA_VALID
);
	// ==========================================================
	// Expected latency
	wire [2:0] exp_mode = READ_KIND == fic_pkg::FIC_RD_DUAL ? 3'h4 : READ_KIND == fic_pkg::FIC_RD_QUAD ? 3'h2
		: READ_KIND == fic_pkg::FIC_RD_DDR_QUAD ? 3'h1 : 3'h0;
	wire [3:0] exp_dummy = READ_KIND == fic_pkg::FIC_RD_PLAIN ? 4'h0
		: READ_KIND == fic_pkg::FIC_RD_PARAM_TABLE ? 4'h8 : CONFIG[3:0];

	// ==========================================================
	// Properties
	sequence s_pulse;
		LINK_RDATA_VALID ##1 !LINK_RDATA_VALID;
	endsequence
	property p_read;
		@(posedge SCK) disable iff (!RESET_N) CMD_STROBE && CMD_OPCODE == 8'h65 |=> s_pulse;
	endproperty
	property p_mode;
		@(posedge CLOCK) disable iff (!RESET_N) CLK_EN |=> MODE_CYCLES == $past(exp_mode);
	endproperty
	property p_dummy;
		@(posedge CLOCK) disable iff (!RESET_N) CLK_EN |=> DUMMY_CYCLES == $past(exp_dummy);
	endproperty
	property p_load;
		@(posedge CLOCK) disable iff (!RESET_N) $rose(RESET_N) |=> CONFIG == (NV_CONFIG & 8'hEF);
	endproperty
	property p_rsv;
		@(posedge CLOCK) disable iff (!RESET_N) !CONFIG[4];
	endproperty
	property p_al;
		@(posedge CLOCK) disable iff (!RESET_N) ADDR_FOUR_BYTES == CONFIG[7];
	endproperty
	property p_quad;
		@(posedge CLOCK) disable iff (!RESET_N) SET_QUAD_IO |-> CONFIG[6] ##1 !SET_QUAD_IO;
	endproperty
	property p_pin;
		@(posedge CLOCK) disable iff (!RESET_N) !CONFIG[5] [*4] |=> !PIN_RESET_REQ;
	endproperty
	a_read: assert property (p_read) else $error("read answer pulse wrong");
	a_mode: assert property (p_mode) else $error("mode cycles wrong");
	a_dummy: assert property (p_dummy) else $error("dummy cycles wrong");
	a_load: assert property (p_load) else $error("reset load wrong");
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	a_al: assert property (p_al) else $error("address length wrong");
	a_quad: assert property (p_quad) else $error("quad enable pulse wrong");
	a_pin: assert property (p_pin) else $error("line three reset while off");
endmodule

bind flash_interface_config fic_sva i_sva
(
	.CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .SCK(SCK), .NV_CONFIG(NV_CONFIG),
	.READ_KIND(READ_KIND), .CMD_STROBE(CMD_STROBE), .CMD_OPCODE(CMD_OPCODE), .CONFIG(CONFIG),
	.ADDR_FOUR_BYTES(ADDR_FOUR_BYTES), .PIN_RESET_REQ(PIN_RESET_REQ), .SET_QUAD_IO(SET_QUAD_IO),
	.MODE_CYCLES(MODE_CYCLES), .DUMMY_CYCLES(DUMMY_CYCLES), .LINK_RDATA_VALID(LINK_RDATA_VALID)
);

// ==== sim/fic_host_model.sv ====
// Host controller model on the link side
`timescale 1ns/1ps
module fic_host_model
(
	output logic SCK,
	output logic CS_N,
	output logic CMD_STROBE,
	output logic [7:0] CMD_OPCODE,
	output logic [7:0] CMD_WDATA,
	input wire logic LINK_BUSY,
	input wire logic LINK_RDATA_VALID,
	input wire logic [7:0] LINK_RDATA
);
	logic err;
	logic [7:0] rdata;
	initial
	begin
		{SCK, CMD_STROBE, err} = 3'h0;
		CS_N = 1;
		{CMD_OPCODE, CMD_WDATA, rdata} = 24'h000000;
	end
	// Link clock 6.25 MHz, far below every rate limit
	task automatic tick;
		#80;
		if (LINK_RDATA_VALID === 1'b1)
			rdata = LINK_RDATA;
		SCK = 1;
		#80 SCK = 0;
	endtask
	// One frame: command, then clocks until the write handshake settles
	task automatic xfer(input logic [7:0] op, input logic [7:0] wd);
		int n;
		n = 0;
		#7 CS_N = 0;
		CMD_STROBE = 1;
		CMD_OPCODE = op;
		CMD_WDATA = wd;
		tick;
		CMD_STROBE = 0;
		CMD_OPCODE = ~op;
		CMD_WDATA = ~wd;
		while ((LINK_BUSY !== 1'b0 || n < 2) && n < 40)
		begin
			tick;
			n++;
		end
		repeat (4) tick;
		err = n >= 40;
		CS_N = 1;
	endtask
endmodule

// ==== sim/flash_interface_config_tb_top.sv ====
// Testbench for the interface configuration register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module flash_interface_config_tb_top;
	logic clock, reset_n, line3, soft_reset, quad_io, clk_en;
	logic [7:0] nv;
	fic_pkg::fic_read_t kind;
	wire sck, cs_n, strobe, busy, rvalid, pin_req, set_quad, four_b, quad_i;
	wire [7:0] opcode, wdata, cfg, rdata;
	wire [2:0] mode;
	wire [3:0] dummy;
	int n_mismatch, n_checks, n_sq;

	initial
	begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end

	flash_interface_config i_dut
	(
		.CLOCK(clock), .RESET_N(reset_n), .CLK_EN(clk_en), .SCK(sck), .CS_N(cs_n), .DATA_LINE_THREE(line3),
		.SOFT_RESET(soft_reset), .QUAD_IO_ENABLE(quad_io), .NV_CONFIG(nv), .READ_KIND(kind),
		.CMD_STROBE(strobe), .CMD_OPCODE(opcode), .CMD_WDATA(wdata), .CONFIG(cfg), .ADDR_FOUR_BYTES(four_b),
		.QUAD_INSTR(quad_i), .PIN_RESET_REQ(pin_req), .SET_QUAD_IO(set_quad), .MODE_CYCLES(mode),
		.DUMMY_CYCLES(dummy), .LINK_RDATA(rdata), .LINK_RDATA_VALID(rvalid), .LINK_BUSY(busy)
	);
	fic_host_model i_host
	(
		.SCK(sck), .CS_N(cs_n), .CMD_STROBE(strobe), .CMD_OPCODE(opcode), .CMD_WDATA(wdata),
		.LINK_BUSY(busy), .LINK_RDATA_VALID(rvalid), .LINK_RDATA(rdata)
	);

	always @(posedge clock)
		if (set_quad === 1'b1)
			n_sq++;

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] wd);
		i_host.xfer(op, wd);
		cyc(2);
		if (i_host.err)
		begin
			n_mismatch++;
			end_of_test;
		end
	endtask
	// Every read kind against one dummy code
	task automatic lat(input logic [3:0] code);
		for (int i = 0; i < 8; i++)
		begin
			kind <= fic_pkg::fic_read_t'(i);
			cyc(2);
			`CHK("mode", i == 2 ? 3'h4 : i == 3 ? 3'h2 : i == 4 ? 3'h1 : 3'h0, mode)
			`CHK("dummy", i == 0 ? 4'h0 : i == 7 ? 4'h8 : code, dummy)
		end
	endtask

	initial
	begin
		{reset_n, soft_reset, line3, quad_io, clk_en} = 5'h07;
		nv = 8'hBA;
		kind = fic_pkg::FIC_RD_PLAIN;
		{n_mismatch, n_checks, n_sq} = 0;
		cyc(10);
		reset_n <= 1;
		cyc(3);
		`CHK("cfg", 8'hAA, cfg)
		$display("test reset done");
		cmd(8'h71, 8'h5F);
		`CHK("cfg", 8'h4F, cfg)
		`CHK("quad_instr", 1'b1, quad_i)
		`CHK("addr_four", 1'b0, four_b)
		`CHK("set_quad", 1, n_sq)
		cmd(8'h65, 8'h00);
		`CHK("rdata", 8'h4F, i_host.rdata)
		cmd(8'h71, 8'h0F);
		`CHK("quad_instr", 1'b0, quad_i)
		cmd(fic_pkg::OP_WIDE_ADDR_DEFAULT, 8'h00);
		`CHK("cfg", 8'h8F, cfg)
		`CHK("addr_four", 1'b1, four_b)
		`CHK("set_quad", 1, n_sq)
		$display("test write done");
		lat(4'hF);
		cmd(8'h71, 8'h20);
		lat(4'h0);
		clk_en <= 0;
		kind <= fic_pkg::FIC_RD_PLAIN;
		cyc(3);
		`CHK("dummy_frozen", 4'h8, dummy)
		clk_en <= 1;
		cyc(2);
		`CHK("dummy", 4'h0, dummy)
		$display("test latency done");
		quad_io <= 0;
		line3 <= 0;
		cyc(6);
		`CHK("pin_req", 1'b1, pin_req)
		`CHK("cfg", 8'hAA, cfg)
		line3 <= 1;
		cyc(6);
		cmd(8'h71, 8'h00);
		line3 <= 0;
		cyc(8);
		`CHK("pin_req", 1'b0, pin_req)
		`CHK("cfg", 8'h00, cfg)
		line3 <= 1;
		soft_reset <= 1;
		cyc(1);
		soft_reset <= 0;
		cyc(3);
		`CHK("cfg", 8'hAA, cfg)
		$display("test pin reset done");
		end_of_test;
	end
endmodule
